// [inc/hlc_cfg.svh]
// Register offsets, field positions, reset values and timing counts of the link port block.
`ifndef HLC_CFG_SVH
`define HLC_CFG_SVH

`define HLC_REG_CTRL          8'h00
`define HLC_REG_COH           8'h04
`define HLC_REG_STAT          8'h08

`define HLC_CTRL_COH_BIT      0
`define HLC_CTRL_FREQ_LSB     1
`define HLC_CTRL_W16_BIT      3
`define HLC_CTRL_RETRAIN_BIT  4
`define HLC_COH_WIN_NUM       4

`define HLC_STAT_UP_BIT       0
`define HLC_STAT_BUSY_BIT     1
`define HLC_STAT_SPLIT_BIT    2
`define HLC_STAT_ROLE_BIT     3
`define HLC_STAT_FREQ_LSB     4
`define HLC_STAT_W16_BIT      6

`define HLC_CTRL_COH_RST      1'b0
`define HLC_CTRL_W16_RST      1'b1
`define HLC_COH_RST           4'h0

`define HLC_ADDR_HALF_BIT     40
`define HLC_SEG_FIRST         7'h06
`define HLC_SEG_SECOND        7'h07

`define HLC_LINK_PERIOD_NS    160
`define HLC_RST_HOLD_NS       1000
`define HLC_INIT_NS           2000
`define HLC_RST_HOLD_CYC ((`HLC_RST_HOLD_NS + `HLC_LINK_PERIOD_NS - 1) / `HLC_LINK_PERIOD_NS)
`define HLC_INIT_CYC     ((`HLC_INIT_NS + `HLC_LINK_PERIOD_NS - 1) / `HLC_LINK_PERIOD_NS)

`endif

// [inc/hlc_pkg.sv]
// Types shared by the link port configuration modules.
package hlc_pkg;
    typedef enum logic [1:0] {
        HLC_F200,
        HLC_F400,
        HLC_F800
    } hlc_freq_e;

    typedef enum logic [1:0] {
        HLC_HOLD,
        HLC_INIT,
        HLC_UP
    } hlc_train_e;

    typedef logic [5:0] hlc_cnt_t;
endpackage : hlc_pkg

// [verilog/hlc_sync.sv]
// Two flip-flop level synchroniser.
module hlc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } hlc_sync_s;

    hlc_sync_s st_q;
    hlc_sync_s st_d;

    always_comb begin
        st_d.meta = d_in;
        st_d.sync = st_q.meta;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q_out = st_q.sync;
endmodule : hlc_sync

// [verilog/hlc_link_trainer.sv]
// Link-clock bring-up sequencer: reset hold, initialisation, link up.
`include "hlc_cfg.svh"
module hlc_link_trainer (
    input  wire logic       link_clk_in,
    input  wire logic       rstn_in,
    input  wire logic       start_tgl_in,
    input  wire logic [1:0] freq_in,
    input  wire logic       w16_in,
    input  wire logic       master_in,
    input  wire logic       split_in,
    input  wire logic [2:0] lo_peer_in,
    input  wire logic [2:0] hi_peer_in,
    output logic            done_tgl_out,
    output logic            up_out,
    output logic            link_rstn_out,
    output logic [1:0]      freq_out,
    output logic            w16_out
);
    typedef struct packed {
        hlc_pkg::hlc_train_e state;
        hlc_pkg::hlc_cnt_t   cnt;
        logic [1:0]          freq;
        logic                w16;
        logic                start_seen;
        logic                req;
        logic                done_tgl;
        logic                up;
        logic                rstn;
    } hlc_trn_s;

    hlc_trn_s   st_q;
    hlc_trn_s   st_d;
    logic [8:0] sy;
    logic       peer_ok;

    hlc_sync #(.W(9)) u_sync (
        .clk_in  (link_clk_in),
        .rstn_in (rstn_in),
        .d_in    ({start_tgl_in, master_in, split_in, hi_peer_in, lo_peer_in}),
        .q_out   (sy)
    );

    always_comb begin
        st_d = st_q;
        // As slave the peer's power-good and reset must be high on every used half.
        peer_ok = sy[7] || (sy[0] && sy[1] && (!sy[6] || (sy[3] && sy[4])));
        if (sy[8] != st_q.start_seen) begin
            // Software asked for new settings: take them and restart the link.
            st_d.start_seen = sy[8];
            st_d.freq       = freq_in;
            st_d.w16        = w16_in;
            st_d.req        = 1'b1;
            st_d.state      = hlc_pkg::HLC_HOLD;
            st_d.cnt        = '0;
        end else if (!peer_ok) begin
            st_d.state = hlc_pkg::HLC_HOLD;
            st_d.cnt   = '0;
        end else begin
            unique case (st_q.state)
                hlc_pkg::HLC_HOLD: begin
                    if (st_q.cnt == 6'(`HLC_RST_HOLD_CYC - 1)) begin
                        st_d.state = hlc_pkg::HLC_INIT;
                        st_d.cnt   = '0;
                        // A split link never comes up wider than one half.
                        st_d.w16   = st_q.w16 && !sy[6];
                    end else begin
                        st_d.cnt = st_q.cnt + 6'h01;
                    end
                end
                hlc_pkg::HLC_INIT: begin
                    if (st_q.cnt == 6'(`HLC_INIT_CYC - 1)) begin
                        st_d.state = hlc_pkg::HLC_UP;
                        st_d.cnt   = '0;
                        if (st_q.req) begin
                            st_d.req      = 1'b0;
                            st_d.done_tgl = !st_q.done_tgl;
                        end
                    end else begin
                        st_d.cnt = st_q.cnt + 6'h01;
                    end
                end
                hlc_pkg::HLC_UP: begin
                end
            endcase
        end
        st_d.up   = (st_d.state == hlc_pkg::HLC_UP);
        st_d.rstn = (st_d.state != hlc_pkg::HLC_HOLD);
    end

    always_ff @(posedge link_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q       <= '0;
            st_q.state <= hlc_pkg::HLC_HOLD;
            st_q.freq  <= hlc_pkg::HLC_F200;
            st_q.w16   <= `HLC_CTRL_W16_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign done_tgl_out  = st_q.done_tgl;
    assign up_out        = st_q.up;
    assign link_rstn_out = st_q.rstn;
    assign freq_out      = st_q.freq;
    assign w16_out       = st_q.w16;
endmodule : hlc_link_trainer

// [verilog/hlc_link_cfg.sv]
// Link port configuration: registers, address split, coherence tagging and sideband direction.
//
// Notes on behaviour
// - First controller can be set to keep caches coherent across chips.
// - Second controller range is never snooped between chips.
// - Per uncached window, software chooses coherent or non-coherent device DMA.
// - Link frequency selectable among 200, 400 and 800 MHz.
// - Link width is 8 or 16 bits, 16 at most.
// - After bring-up, new frequency and width take effect by link reinitialisation.
// - A 16-bit link can act as two independent 8-bit halves.
// - Sideband power-good, reset and stop pins are driven or received.
// - Split mode: address bit 40 picks lower or upper half controller.
// - Unsplit: lower controller owns 16 bits; bit 40 set is invalid.
// - Role select 1 drives sideband as master; 0 relies on peer.
//
// Design decisions made here: the placing of the registers and strobed register access.
`include "hlc_cfg.svh"
module hlc_link_cfg (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic        link_clk_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    input  wire logic        link_split_select_in,
    input  wire logic        lower_link_role_select_in,
    input  wire logic        req_valid_in,
    input  wire logic [47:0] req_addr_in,
    input  wire logic        req_io_in,
    input  wire logic [1:0]  req_window_in,
    output logic             lower_req_out,
    output logic             upper_req_out,
    output logic      [47:0] req_addr_out,
    output logic             req_snoop_out,
    output logic             req_err_out,
    input  wire logic [2:0]  lower_sb_in,
    output logic      [2:0]  lower_sb_out,
    output logic      [2:0]  lower_sb_oe_out,
    input  wire logic [2:0]  upper_sb_in,
    output logic      [2:0]  upper_sb_out,
    output logic      [2:0]  upper_sb_oe_out,
    output logic      [1:0]  link_freq_out,
    output logic             link_w16_out
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        coh_first;
        logic [1:0]  freq;
        logic        w16;
        logic [3:0]  coh_win;
        logic        pend;
        logic        busy;
        logic        done_seen;
        logic [1:0]  app_freq;
        logic        app_w16;
        logic        start_tgl;
        logic        split;
        logic        role;
        logic        captured;
        logic [31:0] rdata;
        logic        lower_req;
        logic        upper_req;
        logic [47:0] req_addr;
        logic        snoop;
        logic        err;
        logic [2:0]  lo_sb;
        logic [2:0]  lo_oe;
        logic [2:0]  hi_sb;
        logic [2:0]  hi_oe;
    } hlc_top_s;

    hlc_top_s   st_q;
    hlc_top_s   st_d;
    logic [5:0] sy;
    logic       sy_valid;
    logic       trn_done_tgl;
    logic       trn_up;
    logic       trn_rstn;
    logic       sy_done;
    logic       sy_up;
    logic       sy_rstn;
    logic       sy_split;
    logic       sy_role;
    logic [6:0] seg;

    ////////////////////////////////////////////////////////////////////////////
    hlc_link_trainer u_trainer (
        .link_clk_in   (link_clk_in),
        .rstn_in       (rstn_in),
        .start_tgl_in  (st_q.start_tgl),
        .freq_in       (st_q.app_freq),
        .w16_in        (st_q.app_w16),
        .master_in     (st_q.role),
        .split_in      (st_q.split),
        .lo_peer_in    (lower_sb_in),
        .hi_peer_in    (upper_sb_in),
        .done_tgl_out  (trn_done_tgl),
        .up_out        (trn_up),
        .link_rstn_out (trn_rstn),
        .freq_out      (link_freq_out),
        .w16_out       (link_w16_out)
    );

    hlc_sync #(.W(6)) u_sync (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .d_in    ({1'b1, trn_done_tgl, trn_up, trn_rstn, link_split_select_in,
                   lower_link_role_select_in}),
        .q_out   (sy)
    );

    // The constant bit marks the moment both synchroniser stages hold pin values.
    assign sy_valid = sy[5];
    assign sy_done  = sy[4];
    assign sy_up    = sy[3];
    assign sy_rstn  = sy[2];
    assign sy_split = sy[1];
    assign sy_role  = sy[0];
    assign seg      = req_addr_in[47:41];

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d           = st_q;
        st_d.rdata     = '0;
        st_d.lower_req = 1'b0;
        st_d.upper_req = 1'b0;
        st_d.err       = 1'b0;
        st_d.captured  = st_q.captured || sy_valid;

        // Straps are caught once the synchroniser has settled after reset, then only when a retrain is launched
        // (a peer drop restarts the link without them); earlier the synchroniser still shows its reset zeros.
        if (!st_q.captured && sy_valid) begin
            st_d.split = sy_split;
            st_d.role  = sy_role;
            st_d.app_w16 = st_q.w16 && !sy_split;
        end

        // Retrain handshake with the link-clock sequencer.
        if (sy_done != st_q.done_seen) begin
            st_d.done_seen = sy_done;
            st_d.busy      = 1'b0;
        end
        if (st_q.pend && !st_q.busy && st_q.captured && sy_up) begin
            st_d.pend      = 1'b0;
            st_d.busy      = 1'b1;
            st_d.start_tgl = !st_q.start_tgl;
            st_d.app_freq  = st_q.freq;
            st_d.app_w16   = st_q.w16 && !sy_split;
            st_d.split     = sy_split;
            st_d.role      = sy_role;
        end

        // Register writes; a retrain request written now beats the launch above.
        if (reg_wr_in) begin
            if (reg_addr_in == `HLC_REG_CTRL) begin
                st_d.coh_first = reg_wdata_in[`HLC_CTRL_COH_BIT];
                if (reg_wdata_in[`HLC_CTRL_FREQ_LSB+1 -: 2] != 2'h3) begin
                    st_d.freq = reg_wdata_in[`HLC_CTRL_FREQ_LSB+1 -: 2];
                end
                st_d.w16 = reg_wdata_in[`HLC_CTRL_W16_BIT];
                if (reg_wdata_in[`HLC_CTRL_RETRAIN_BIT]) begin
                    st_d.pend = 1'b1;
                end
            end else if (reg_addr_in == `HLC_REG_COH) begin
                st_d.coh_win = reg_wdata_in[`HLC_COH_WIN_NUM-1:0];
            end
        end

        // Register reads answer in the next cycle only.
        if (reg_rd_in) begin
            if (reg_addr_in == `HLC_REG_CTRL) begin
                st_d.rdata[`HLC_CTRL_COH_BIT]            = st_q.coh_first;
                st_d.rdata[`HLC_CTRL_FREQ_LSB+1 -: 2]    = st_q.freq;
                st_d.rdata[`HLC_CTRL_W16_BIT]            = st_q.w16;
                st_d.rdata[`HLC_CTRL_RETRAIN_BIT]        = st_q.pend;
            end else if (reg_addr_in == `HLC_REG_COH) begin
                st_d.rdata[`HLC_COH_WIN_NUM-1:0]         = st_q.coh_win;
            end else if (reg_addr_in == `HLC_REG_STAT) begin
                st_d.rdata[`HLC_STAT_UP_BIT]             = sy_up;
                st_d.rdata[`HLC_STAT_BUSY_BIT]           = st_q.busy || st_q.pend;
                st_d.rdata[`HLC_STAT_SPLIT_BIT]          = st_q.split;
                st_d.rdata[`HLC_STAT_ROLE_BIT]           = st_q.role;
                st_d.rdata[`HLC_STAT_FREQ_LSB+1 -: 2]    = st_q.app_freq;
                st_d.rdata[`HLC_STAT_W16_BIT]            = st_q.app_w16;
            end
        end

        // Request steering by address bit 40 and coherence tagging.
        if (req_valid_in) begin
            st_d.req_addr = req_addr_in;
            if (!sy_up || (req_addr_in[`HLC_ADDR_HALF_BIT] && !st_q.split)) begin
                st_d.err = 1'b1;
            end else begin
                st_d.lower_req = !req_addr_in[`HLC_ADDR_HALF_BIT];
                st_d.upper_req = req_addr_in[`HLC_ADDR_HALF_BIT];
            end
            if (seg == `HLC_SEG_FIRST) begin
                st_d.snoop = st_q.coh_first;
            end else if (seg == `HLC_SEG_SECOND) begin
                st_d.snoop = 1'b0;
            end else begin
                st_d.snoop = req_io_in && st_q.coh_win[req_window_in];
            end
        end

        // Sideband pins: bit 0 power-good, bit 1 reset, bit 2 stop, all active low but 0.
        st_d.lo_sb = {1'b1, sy_rstn, 1'b1};
        st_d.lo_oe = st_q.role ? 3'h7 : 3'h0;
        st_d.hi_sb = st_q.split ? {1'b1, sy_rstn, 1'b1} : 3'h0;
        st_d.hi_oe = (st_q.role && st_q.split) ? 3'h7 : 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q           <= '0;
            st_q.coh_first <= `HLC_CTRL_COH_RST;
            st_q.freq      <= hlc_pkg::HLC_F200;
            st_q.w16       <= `HLC_CTRL_W16_RST;
            st_q.coh_win   <= `HLC_COH_RST;
            st_q.app_freq  <= hlc_pkg::HLC_F200;
            st_q.app_w16   <= `HLC_CTRL_W16_RST;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign reg_rdata_out   = st_q.rdata;
    assign lower_req_out   = st_q.lower_req;
    assign upper_req_out   = st_q.upper_req;
    assign req_addr_out    = st_q.req_addr;
    assign req_snoop_out   = st_q.snoop;
    assign req_err_out     = st_q.err;
    assign lower_sb_out    = st_q.lo_sb;
    assign lower_sb_oe_out = st_q.lo_oe;
    assign upper_sb_out    = st_q.hi_sb;
    assign upper_sb_oe_out = st_q.hi_oe;
endmodule : hlc_link_cfg

// [dv/hlc_link_cfg_properties.sv]
// Concurrent checks on the ports of the link port configuration block.
module hlc_link_cfg_chk (
    input wire logic        clk_in,
    input wire logic        rstn_in,
    input wire logic        req_valid_in,
    input wire logic [47:0] req_addr_in,
    input wire logic        lower_req_out,
    input wire logic        upper_req_out,
    input wire logic        req_err_out,
    input wire logic [47:0] req_addr_out,
    input wire logic        req_snoop_out,
    input wire logic [2:0]  lower_sb_out,
    input wire logic [2:0]  lower_sb_oe_out,
    input wire logic [2:0]  upper_sb_out,
    input wire logic [2:0]  upper_sb_oe_out,
    input wire logic [1:0]  link_freq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    property p_one_answer; req_valid_in |=> $onehot({lower_req_out, upper_req_out, req_err_out}); endproperty
    a_one_answer: assert property (p_one_answer) else $error("request answer not unique");
    property p_quiet; !req_valid_in |=> !(lower_req_out || upper_req_out || req_err_out); endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_half; (lower_req_out || upper_req_out) |-> req_addr_out[40] == upper_req_out; endproperty
    a_half: assert property (p_half) else $error("half does not match bit 40");
    property p_unsplit; upper_req_out |-> upper_sb_out[0]; endproperty
    a_unsplit: assert property (p_unsplit) else $error("upper half used while unsplit");
    property p_second; req_valid_in && req_addr_in[47:41] == 7'h07 |=> !req_snoop_out; endproperty
    a_second: assert property (p_second) else $error("second range snooped");
    property p_addr; req_valid_in |=> req_addr_out == $past(req_addr_in); endproperty
    a_addr: assert property (p_addr) else $error("forwarded address differs");
    property p_upper_oe; |upper_sb_oe_out |-> upper_sb_oe_out == 3'h7 && lower_sb_oe_out == 3'h7; endproperty
    a_upper_oe: assert property (p_upper_oe) else $error("upper sideband enable wrong");
    property p_master_lvl; lower_sb_oe_out == 3'h7 |-> lower_sb_out[0] && lower_sb_out[2]; endproperty
    a_master_lvl: assert property (p_master_lvl) else $error("master sideband level wrong");
    property p_freq; link_freq_out != 2'h3; endproperty
    a_freq: assert property (p_freq) else $error("illegal link frequency");

    c_upper: cover property (upper_req_out);
    c_err: cover property (req_err_out);
    c_snoop: cover property (lower_req_out && req_snoop_out);
endmodule : hlc_link_cfg_chk

bind hlc_link_cfg hlc_link_cfg_chk u_chk (
    .clk_in(clk_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in),
    .req_addr_in(req_addr_in), .lower_req_out(lower_req_out), .upper_req_out(upper_req_out),
    .req_err_out(req_err_out), .req_addr_out(req_addr_out), .req_snoop_out(req_snoop_out),
    .lower_sb_out(lower_sb_out), .lower_sb_oe_out(lower_sb_oe_out),
    .upper_sb_out(upper_sb_out), .upper_sb_oe_out(upper_sb_oe_out),
    .link_freq_out(link_freq_out));

// [dv/hlc_peer_model.sv]
// Peer link device that owns the sideband lines while this end is the slave.
module hlc_peer_model (
    input  wire logic       link_clk_in,
    input  wire logic       slave_in,
    input  wire logic       ready_in,
    input  wire logic [2:0] lo_drv_in,
    input  wire logic [2:0] lo_oe_in,
    input  wire logic [2:0] hi_drv_in,
    input  wire logic [2:0] hi_oe_in,
    output logic      [2:0] lo_pin_out,
    output logic      [2:0] hi_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] peer_q = 3'h0;
    // Power-good and reset_n rise together once the peer is ready; stop_n stays high.
    always_ff @(posedge link_clk_in) begin
        peer_q <= {1'b1, ready_in, ready_in};
    end
    // Lines nobody drives fall to their pull-down level.
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            lo_pin_out[i] = lo_oe_in[i] ? lo_drv_in[i] : (slave_in & peer_q[i]);
            hi_pin_out[i] = hi_oe_in[i] ? hi_drv_in[i] : (slave_in & peer_q[i]);
        end
    end
endmodule : hlc_peer_model

// [dv/tb_ht_link_port_configuration.sv]
// Self-checking bench for the link port configuration block.
`include "hlc_cfg.svh"
module tb_ht_link_port_configuration;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0, link_clk = 1'b0, rstn_in = 1'b0, split = 1'b0, role = 1'b1, ready = 1'b0;
    logic [7:0]  reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, d;
    logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, req_valid_in = 1'b0, req_io_in = 1'b0;
    logic [47:0] req_addr_in = 48'h0, req_addr_out;
    logic [1:0]  req_window_in = 2'h0, link_freq_out;
    logic        lower_req_out, upper_req_out, req_snoop_out, req_err_out, link_w16_out;
    logic [2:0]  lo_pin, hi_pin, lower_sb_out, lower_sb_oe_out, upper_sb_out, upper_sb_oe_out;
    int          failures = 0, checked = 0, cycles = 0;

    always #5 clk_in = ~clk_in;
    always #80 link_clk = ~link_clk;

    hlc_link_cfg dut (
        .clk_in(clk_in), .rstn_in(rstn_in), .link_clk_in(link_clk), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .link_split_select_in(split),
        .lower_link_role_select_in(role), .req_valid_in(req_valid_in),
        .req_addr_in(req_addr_in), .req_io_in(req_io_in), .req_window_in(req_window_in),
        .lower_req_out(lower_req_out), .upper_req_out(upper_req_out),
        .req_addr_out(req_addr_out), .req_snoop_out(req_snoop_out), .req_err_out(req_err_out),
        .lower_sb_in(lo_pin), .lower_sb_out(lower_sb_out), .lower_sb_oe_out(lower_sb_oe_out),
        .upper_sb_in(hi_pin), .upper_sb_out(upper_sb_out), .upper_sb_oe_out(upper_sb_oe_out),
        .link_freq_out(link_freq_out), .link_w16_out(link_w16_out));

    hlc_peer_model peer (
        .link_clk_in(link_clk), .slave_in(~role), .ready_in(ready),
        .lo_drv_in(lower_sb_out), .lo_oe_in(lower_sb_oe_out), .hi_drv_in(upper_sb_out),
        .hi_oe_in(upper_sb_oe_out), .lo_pin_out(lo_pin), .hi_pin_out(hi_pin));

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        v = reg_rdata_out;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk("register", exp, v);
    endtask : rchk

    task automatic req(input logic [47:0] a, input logic io, input logic [1:0] w,
                       input logic [2:0] exp, input logic snp);
        @(posedge clk_in);
        req_valid_in  <= 1'b1;
        req_addr_in   <= a;
        req_io_in     <= io;
        req_window_in <= w;
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        #1;
        chk("answer", exp, {lower_req_out, upper_req_out, req_err_out});
        if (!exp[0]) chk("snoop", snp, req_snoop_out);
    endtask : req

    task automatic do_reset(input logic s, input logic r);
        split <= s;
        role  <= r;
        repeat (3) @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (5) @(posedge link_clk);
        @(posedge clk_in);
        rstn_in <= 1'b1;
    endtask : do_reset

    task automatic wait_up();
        int n;
        n = 0;
        do begin
            rd(`HLC_REG_STAT, d);
            n++;
        end while (!(d[0] === 1'b1 && d[1] === 1'b0) && n < 3000);
        chk("link up", 2'b01, d[1:0]);
    endtask : wait_up

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b0, 1'b1);
        chk("width", 1, link_w16_out);
        req(48'h0C00_0000_0000, 1'b0, 2'h0, 3'b001, 1'b0);
        wait_up();
        rchk(`HLC_REG_CTRL, 32'h8);
        rchk(`HLC_REG_STAT, 32'h49);
        chk("lower oe", 3'h7, lower_sb_oe_out);
        chk("upper oe", 3'h0, upper_sb_oe_out);
        split <= 1'b1;
        repeat (10) @(posedge clk_in);
        rchk(`HLC_REG_STAT, 32'h49);
        split <= 1'b0;
        wr(8'h0C, 32'hFFFFFFFF);
        rchk(8'h0C, 32'h0);
        $display("test reset done");
        req(48'h0C00_0000_0000, 1'b0, 2'h0, 3'b100, 1'b0);
        wr(`HLC_REG_CTRL, 32'h9);
        req(48'h0C00_0000_0000, 1'b0, 2'h0, 3'b100, 1'b1);
        wr(`HLC_REG_COH, 32'h5);
        for (int w = 0; w < 4; w++) begin
            req(48'h0000_1000_0000, 1'b1, w[1:0], 3'b100, w[0] == 1'b0);
        end
        req(48'h0000_1000_0000, 1'b0, 2'h0, 3'b100, 1'b0);
        wr(`HLC_REG_COH, 32'hF);
        req(48'h0E00_0000_0000, 1'b1, 2'h1, 3'b100, 1'b0);
        req(48'h0D00_0000_0000, 1'b0, 2'h0, 3'b001, 1'b0);
        $display("test requests done");
        for (int f = 2; f >= 0; f--) begin
            wr(`HLC_REG_CTRL, 32'h19 | (f << 1));
            wait_up();
            chk("freq", f, link_freq_out);
            rchk(`HLC_REG_STAT, 32'h49 | (f << 4));
        end
        wr(`HLC_REG_CTRL, 32'h0F);
        rchk(`HLC_REG_CTRL, 32'h09);
        wr(`HLC_REG_CTRL, 32'h11);
        wait_up();
        chk("width", 0, link_w16_out);
        $display("test retrain done");
        do_reset(1'b1, 1'b1);
        wait_up();
        chk("width", 0, link_w16_out);
        chk("upper oe", 3'h7, upper_sb_oe_out);
        req(48'h0100_0000_0000, 1'b0, 2'h0, 3'b010, 1'b0);
        req(48'h0000_0000_0000, 1'b0, 2'h0, 3'b100, 1'b0);
        rchk(`HLC_REG_STAT, 32'h0D);
        $display("test split done");
        ready <= 1'b0;
        do_reset(1'b0, 1'b0);
        repeat (200) @(posedge clk_in);
        rd(`HLC_REG_STAT, d);
        chk("up while peer idle", 0, d[0]);
        chk("lower oe", 3'h0, lower_sb_oe_out);
        ready <= 1'b1;
        wait_up();
        $display("test slave done");
        stop_test();
    end
endmodule : tb_ht_link_port_configuration
